// ---- rtl/usp_pkg.sv ----
/*
 Shared constants, state type and decode functions of the serial port.
 Assumes a 20 MHz peripheral clock; all users import the whole package.
*/
package usp_pkg;
	localparam int unsigned CLK_HZ         = 20_000_000;
	// Operating modes
	localparam logic [1:0]  MODE_ASYNC     = 2'h0;
	localparam logic [1:0]  MODE_SYNC_MST  = 2'h1;
	localparam logic [1:0]  MODE_SYNC_SLV  = 2'h2;
	localparam logic [1:0]  MODE_SPI       = 2'h3;
	// Parity field: bit 1 enables, bit 0 selects odd
	localparam int unsigned PAR_EN_BIT     = 1;
	localparam int unsigned PAR_ODD_BIT    = 0;
	// Frame widths
	localparam logic [3:0]  BITS_MIN       = 4'h5;
	localparam logic [3:0]  BITS_MAX       = 4'h9;
	// Samples per bit, normal and double speed
	localparam logic [4:0]  SAMPLES_NORMAL = 5'h10;
	localparam logic [4:0]  SAMPLES_DOUBLE = 5'h08;
	// Fractional divider: 64 steps per divider unit, floor keeps rate <= clk/8
	localparam logic [15:0] FRAC_STEP      = 16'h0040;
	localparam logic [9:0]  HALF_MIN       = 10'h001;
	// Infrared pulse: 3 sample ticks, 3 of 16 at normal speed and 3 of 8 at double speed, valid up to 115200 bit/s
	localparam logic [4:0]  IR_PULSE_TICKS = 5'h03;
	localparam int unsigned IR_MAX_BPS     = 115_200;
	// Reset values and sync field fall count
	localparam logic [15:0] DIV_RST        = 16'h0000;
	localparam logic [16:0] AB_CNT_RST     = 17'h0_0000;
	localparam logic [2:0]  AB_FALLS       = 3'h5;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_START = 3'b001,
		ST_DATA  = 3'b010,
		ST_PAR   = 3'b011,
		ST_STOP  = 3'b100
	} usp_state_t;

	// Clamp the data bit count to 5..9
	function automatic logic [3:0] usp_nbits(input logic [3:0] c);
		return (c < BITS_MIN) ? BITS_MIN : ((c > BITS_MAX) ? BITS_MAX : c);
	endfunction

	// Bit position of the idx-th bit on the wire
	function automatic logic [3:0] usp_pos(input logic [3:0] idx, input logic [3:0] n,
		input logic msb);
		return msb ? 4'(n - 4'h1 - idx) : idx;
	endfunction

	// Parity over the low n bits; odd starts from one
	function automatic logic usp_parity(input logic [8:0] d, input logic [3:0] n,
		input logic odd);
		logic p;
		p = odd;
		for (int i = 0; i < 9; i++) begin
			if (i < int'(n)) begin
				p = p ^ d[i];
			end
		end
		return p;
	endfunction
endpackage

// ---- rtl/usp_baud_if.sv ----
/*
 Carrier between the serial port core and its baud generator.
 Assumes both ends run on the same peripheral clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface usp_baud_if;
	logic [15:0] div;
	logic        sync_mode;
	logic        run;
	logic        tick;
	logic        transfer_clock_pin;
	logic        xck_rise;
	logic        xck_fall;
	modport gen  (input div, sync_mode, run, output tick, transfer_clock_pin, xck_rise, xck_fall);
	modport user (output div, sync_mode, run, input tick, transfer_clock_pin, xck_rise, xck_fall);
endinterface
`default_nettype wire

// ---- rtl/usp_baud_gen.sv ----
/*
 Fractional baud generator: sample ticks for asynchronous modes and a
 half-period divided bit clock for synchronous and SPI master modes.
 Assumes the divider is changed only while no frame is moving.
*/
`timescale 1ns/1ps
`default_nettype none
module usp_baud_gen import usp_pkg::*; (
	input  wire logic clk,
	input  wire logic sys_rst,
	usp_baud_if.gen   bif
);
	logic [15:0] acc_reg;
	logic [15:0] acc_next;
	logic [9:0]  half_reg;
	logic        xck_reg;
	logic        tick_reg;

	// Divider below one unit would beat clk/8 per bit, so it is clamped
	wire  [15:0] eff_div  = (bif.div < FRAC_STEP) ? FRAC_STEP : bif.div; // [R5]
	wire  [16:0] acc_sum  = {1'b0, acc_reg} + {1'b0, FRAC_STEP};
	wire         acc_hit  = acc_sum >= {1'b0, eff_div};                  // [R21]
	// Only the integer part counts in synchronous modes, least one cycle
	wire  [9:0]  half_lim = (bif.div[15:6] < HALF_MIN) ? HALF_MIN : bif.div[15:6];
	wire         half_hit = bif.run && (half_reg >= half_lim - HALF_MIN); // [R4] [R12]

	assign acc_next     = acc_hit ? 16'(acc_sum - {1'b0, eff_div}) : acc_sum[15:0];
	assign bif.tick     = tick_reg;
	assign bif.transfer_clock_pin      = xck_reg;
	assign bif.xck_rise = half_hit && !xck_reg && bif.sync_mode;
	assign bif.xck_fall = half_hit && xck_reg && bif.sync_mode;

	// Accumulator and clock divider
	always_ff @(posedge clk) begin
		if (sys_rst || !bif.run) begin
			acc_reg  <= DIV_RST;
			half_reg <= 10'h000;
			xck_reg  <= 1'b0;
			tick_reg <= 1'b0;
		end else begin
			acc_reg  <= acc_next;
			tick_reg <= acc_hit && !bif.sync_mode;
			half_reg <= half_hit ? 10'h000 : 10'(half_reg + 10'h001);
			xck_reg  <= half_hit ? !xck_reg : xck_reg;
		end
	end
endmodule // usp_baud_gen
`default_nettype wire

// ---- rtl/usp_top.sv ----
/*
 Serial port core: asynchronous, synchronous and SPI master framing,
 buffered transmitter, two-entry receiver, filters, infrared codec,
 break detection with auto-baud, RS-485 driver enable.
 Assumes pins are outside the clock domain; configuration is static
 while frames move; software owns the plain control ports.
// Functional notes
// R1 - Start bit, five to nine bits, either order
// R2 - Optional even/odd parity, one or two stops
// R3 - Next start follows directly or line idles high
// R4 - Synchronous bit clock at most half clock
// R5 - Asynchronous bit rate at most eighth clock
// R6 - One transmit buffer feeds gapless next frame
// R7 - Two-entry receive buffer, asynchronous recovery
// R8 - Frame, parity, overflow errors flagged separately
// R9 - Separate transmit-complete, empty, receive-complete requests
// R10 - One-wire mode shares receive pin both ways
// R11 - SPI drops asynchronous logic, keeps buffers
// R12 - SPI double buffered, bit order, half clock
// R13 - Unaddressed multiprocessor receiver drops frames
// R14 - False start rejection and majority filter
// R15 - Slave bit clock comes from transfer pin
// R16 - Infrared pulse codec up to 115.2 kbps
// R17 - Break detection and automatic rate measurement
// R18 - Driver enable output while transmitting
// R19 - Start of frame detection in asynchronous mode
// R20 - Transfer clock pin drives or receives clock
// R21 - Rate divider ten integer, six fraction bits
// R22 - Double speed uses eight samples per bit
*/
`timescale 1ns/1ps
`default_nettype none
module usp_top import usp_pkg::*; (
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic        tx_enable,
	input  wire logic        rx_enable,
	input  wire logic [1:0]  op_mode,
	input  wire logic [3:0]  data_bits,
	input  wire logic        msb_first,
	input  wire logic [1:0]  parity_mode,
	input  wire logic        two_stop,
	input  wire logic        double_speed_sampling,
	input  wire logic        one_wire,
	input  wire logic        multiproc,
	input  wire logic        infrared_pulse_codec,
	input  wire logic        lin_auto_baud,
	input  wire logic [15:0] baud_div,
	input  wire logic [8:0]  tx_data,
	input  wire logic        tx_write,
	output logic             tx_ready,
	output logic [8:0]       rx_data,
	output logic             rx_frame_err,
	output logic             rx_parity_err,
	output logic             rx_valid,
	input  wire logic        rx_read,
	output logic             rx_overflow,
	input  wire logic        txc_clear,
	output logic             txc_irq,
	output logic             dre_irq,
	output logic             rxc_irq,
	output logic             start_of_frame,
	output logic             break_detect,
	output logic [15:0]      auto_baud,
	output logic             auto_baud_valid,
	input  wire logic        rxd_in,
	output logic             rxd_out,
	output logic             rxd_oe,
	output logic             txd,
	input  wire logic        transfer_clock_pin_in,
	output logic             transfer_clock_pin_out,
	output logic             transfer_clock_pin_oe,
	output logic             rs485_driver_enable
);
	usp_baud_if bif ();
	usp_baud_gen u_baud (.clk(clk), .sys_rst(sys_rst), .bif(bif));

	// Mode decode
	wire        is_async = op_mode == MODE_ASYNC;
	wire        is_spi   = op_mode == MODE_SPI;                         // [R11]
	wire        is_slave = op_mode == MODE_SYNC_SLV;
	wire [3:0]  nbits    = usp_nbits(data_bits);                        // [R1]
	wire        par_en   = parity_mode[PAR_EN_BIT] && !is_spi;          // [R2] [R11]
	wire [4:0]  samples  = double_speed_sampling ? SAMPLES_DOUBLE : SAMPLES_NORMAL; // [R22]
	wire        ir_on    = infrared_pulse_codec && is_async;            // [R16]

	// Two-flop synchronisers for the receive and clock pins
	logic [1:0] sync1_reg;
	logic [1:0] sync2_reg;
	logic       xck_d_reg;
	always_ff @(posedge clk) begin
		sync1_reg <= {transfer_clock_pin_in, rxd_in};
		sync2_reg <= sync1_reg;
		xck_d_reg <= sync2_reg[1];
	end
	wire rx_raw = sync2_reg[0];
	// Slave edges come from the sampled pin, master edges from the divider
	wire clk_rise = is_slave ? (sync2_reg[1] && !xck_d_reg) : bif.xck_rise; // [R15]
	wire clk_fall = is_slave ? (!sync2_reg[1] && xck_d_reg) : bif.xck_fall; // [R15]

	// Transmitter
	usp_state_t tx_state_reg, tx_state_next;
	logic [8:0] tx_buf_reg, tx_shift_reg, tx_shift_next;
	logic [3:0] tx_idx_reg, tx_idx_next;
	logic [4:0] tx_cnt_reg;
	logic       tx_full_reg, tx_full_next, tx_line_reg, tx_line_next;
	logic       tx_stop2_reg, tx_stop2_next, txc_reg, txd_reg, oe_reg;

	wire tx_cnt_end = tx_cnt_reg == samples - 5'h01;
	wire tx_step    = is_async ? (bif.tick && tx_cnt_end) : clk_rise;
	wire tx_par     = usp_parity(tx_shift_reg, nbits, parity_mode[PAR_ODD_BIT]);
	wire tx_last    = (tx_state_reg == ST_DATA && tx_idx_reg == nbits - 4'h1 && is_spi) ||
		(tx_state_reg == ST_STOP && !tx_stop2_reg);
	// A full buffer is taken at the end of the frame with no idle gap
	wire tx_go      = tx_step && tx_full_reg && tx_enable &&
		(tx_state_reg == ST_IDLE || tx_last);                           // [R6]
	wire tx_done    = tx_step && tx_last && !tx_go;
	wire tx_bit_n   = tx_shift_reg[usp_pos(4'(tx_idx_reg + 4'h1), nbits, msb_first)];

	assign tx_ready = !tx_full_reg && tx_enable;

	// Next-state of the transmit frame
	always_comb begin
		tx_state_next = tx_state_reg;
		tx_shift_next = tx_shift_reg;
		tx_idx_next   = tx_idx_reg;
		tx_line_next  = tx_line_reg;
		tx_stop2_next = tx_stop2_reg;
		tx_full_next  = tx_full_reg || (tx_write && tx_ready);
		if (tx_go) begin
			tx_shift_next = tx_buf_reg;
			tx_full_next  = 1'b0;
			tx_idx_next   = 4'h0;
			// SPI carries no start bit
			tx_state_next = is_spi ? ST_DATA : ST_START;                // [R11]
			tx_line_next  = is_spi ? tx_buf_reg[usp_pos(4'h0, nbits, msb_first)] : 1'b0; // [R1]
		end else if (tx_done) begin
			tx_state_next = ST_IDLE;                                    // [R3]
			tx_line_next  = 1'b1;
		end else if (tx_step) begin
			case (tx_state_reg)
				ST_START: begin
					tx_state_next = ST_DATA;
					tx_line_next  = tx_shift_reg[usp_pos(4'h0, nbits, msb_first)];
				end
				ST_DATA: begin
					if (tx_idx_reg == nbits - 4'h1) begin
						tx_state_next = par_en ? ST_PAR : ST_STOP;      // [R2]
						tx_line_next  = par_en ? tx_par : 1'b1;
						tx_stop2_next = two_stop;
					end else begin
						tx_idx_next  = 4'(tx_idx_reg + 4'h1);
						tx_line_next = tx_bit_n;
					end
				end
				ST_PAR: begin
					tx_state_next = ST_STOP;
					tx_line_next  = 1'b1;
					tx_stop2_next = two_stop;
				end
				ST_STOP: tx_stop2_next = 1'b0;                          // [R2]
				default: tx_state_next = ST_IDLE;
			endcase
		end
	end

	// Infrared: a zero becomes a short low pulse, a one stays high
	wire txd_next = ir_on ? !(!tx_line_reg && tx_cnt_reg < IR_PULSE_TICKS) : tx_line_reg; // [R16]

	// Transmit registers; a completion set beats a same-cycle clear
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			tx_state_reg <= ST_IDLE;
			tx_shift_reg <= 9'h000;
			tx_buf_reg   <= 9'h000;
			tx_idx_reg   <= 4'h0;
			tx_cnt_reg   <= 5'h00;
			tx_full_reg  <= 1'b0;
			tx_line_reg  <= 1'b1;
			tx_stop2_reg <= 1'b0;
			txc_reg      <= 1'b0;
			txd_reg      <= 1'b1;
			oe_reg       <= 1'b0;
		end else begin
			tx_state_reg <= tx_state_next;
			tx_shift_reg <= tx_shift_next;
			tx_buf_reg   <= (tx_write && tx_ready) ? tx_data : tx_buf_reg;
			tx_idx_reg   <= tx_idx_next;
			tx_cnt_reg   <= bif.tick ? (tx_cnt_end ? 5'h00 : 5'(tx_cnt_reg + 5'h01)) : tx_cnt_reg;
			tx_full_reg  <= tx_full_next;
			tx_line_reg  <= tx_line_next;
			tx_stop2_reg <= tx_stop2_next;
			txc_reg      <= tx_done || (txc_reg && !txc_clear);          // [R9]
			txd_reg      <= txd_next;
			oe_reg       <= one_wire && tx_enable;                       // [R10]
		end
	end

	// Pins and requests
	assign txd                    = txd_reg;
	assign rxd_out                = txd_reg;                             // [R10]
	assign rxd_oe                 = oe_reg;                              // [R10]
	assign rs485_driver_enable    = tx_state_reg != ST_IDLE;             // [R18]
	assign transfer_clock_pin_out = bif.transfer_clock_pin;
	assign transfer_clock_pin_oe  = op_mode == MODE_SYNC_MST || is_spi;  // [R20]
	assign txc_irq                = txc_reg;                             // [R9]
	assign dre_irq                = tx_ready;                            // [R9]

	// Divider feed; SPI clock runs only while data waits or moves
	logic [15:0] ab_reg;
	logic        ab_valid_reg;
	assign bif.div       = ab_valid_reg ? ab_reg : baud_div;             // [R17]
	assign bif.sync_mode = !is_async;
	assign bif.run       = is_spi ? (tx_full_reg || tx_state_reg != ST_IDLE) : 1'b1; // [R11]

	// Receiver front end: infrared stretch and majority of three
	logic [4:0] ir_cnt_reg, rx_cnt_reg;
	logic       ir_hold_reg;
	logic [2:0] rx_hist_reg;
	wire        rx_in  = ir_on ? ir_hold_reg : rx_raw;                   // [R16]
	wire        rx_maj = (rx_hist_reg[0] & rx_hist_reg[1]) | (rx_hist_reg[1] & rx_hist_reg[2]) |
		(rx_hist_reg[0] & rx_hist_reg[2]);                              // [R14]
	wire        rx_eval = bif.tick && rx_cnt_reg == 5'((samples >> 1) + 5'h01);
	wire        rx_evt  = is_async ? rx_eval : clk_fall;
	wire        rx_bitv = is_async ? rx_maj : rx_in;

	usp_state_t rx_state_reg, rx_state_next;
	logic [8:0] rx_shift_reg, rx_shift_next;
	logic [3:0] rx_idx_reg, rx_idx_next;
	logic       rx_perr_reg, rx_perr_next, rx_push, rx_ferr, sof_reg, sof_next;

	wire rx_start = rx_enable && rx_state_reg == ST_IDLE && (is_spi ? tx_go :
		(is_async ? !rx_in : (clk_fall && !rx_in)));

	// Next-state of the receive frame
	always_comb begin
		rx_state_next = rx_state_reg;
		rx_shift_next = rx_shift_reg;
		rx_idx_next   = rx_idx_reg;
		rx_perr_next  = rx_perr_reg;
		rx_push       = 1'b0;
		rx_ferr       = 1'b0;
		sof_next      = 1'b0;
		if (rx_start) begin
			rx_state_next = is_async ? ST_START : ST_DATA;
			rx_shift_next = 9'h000;
			rx_idx_next   = 4'h0;
			rx_perr_next  = 1'b0;
		end else if (rx_evt) begin
			case (rx_state_reg)
				ST_START: begin
					// A start that reads high at mid-bit was noise
					rx_state_next = rx_bitv ? ST_IDLE : ST_DATA;        // [R14]
					sof_next      = !rx_bitv;                           // [R19]
				end
				ST_DATA: begin
					rx_shift_next[usp_pos(rx_idx_reg, nbits, msb_first)] = rx_bitv; // [R1]
					rx_idx_next = 4'(rx_idx_reg + 4'h1);
					if (rx_idx_reg == nbits - 4'h1) begin
						rx_state_next = is_spi ? ST_IDLE : (par_en ? ST_PAR : ST_STOP);
						rx_push       = is_spi;
					end
				end
				ST_PAR: begin
					rx_perr_next  = rx_bitv != usp_parity(rx_shift_reg, nbits,
						parity_mode[PAR_ODD_BIT]);                      // [R8]
					rx_state_next = ST_STOP;
				end
				ST_STOP: begin
					rx_ferr       = !rx_bitv;                           // [R8]
					rx_push       = 1'b1;
					rx_state_next = ST_IDLE;
				end
				default: rx_state_next = ST_IDLE;
			endcase
		end
	end

	// Unaddressed receivers drop data frames; address frames carry bit 8 set
	wire rx_drop = multiproc && !is_spi && nbits == BITS_MAX && !rx_shift_reg[8]; // [R13]
	wire rx_brk  = rx_push && rx_ferr && rx_shift_reg == 9'h000;         // [R17]

	// Two-entry receive buffer
	logic [10:0] rx_mem [2];
	logic        rx_wp_reg, rx_rp_reg, ovf_reg;
	logic [1:0]  rx_cnt2_reg;
	wire         rx_pop  = rx_read && rx_cnt2_reg != 2'h0;
	wire         rx_keep = rx_push && !rx_drop;
	wire         rx_wr   = rx_keep && (rx_cnt2_reg != 2'h2 || rx_pop);   // [R7]
	wire         rx_ovf  = rx_keep && !rx_wr;                            // [R8]

	// Front-end and receive frame registers
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rx_state_reg <= ST_IDLE;
			rx_shift_reg <= 9'h000;
			rx_idx_reg   <= 4'h0;
			rx_perr_reg  <= 1'b0;
			rx_cnt_reg   <= 5'h00;
			rx_hist_reg  <= 3'h7;
			ir_hold_reg  <= 1'b1;
			ir_cnt_reg   <= 5'h00;
			sof_reg      <= 1'b0;
		end else begin
			rx_state_reg <= rx_state_next;
			rx_shift_reg <= rx_shift_next;
			rx_idx_reg   <= rx_idx_next;
			rx_perr_reg  <= rx_perr_next;
			sof_reg      <= sof_next;
			rx_cnt_reg   <= rx_start ? 5'h00 : (bif.tick ?
				((rx_cnt_reg == samples - 5'h01) ? 5'h00 : 5'(rx_cnt_reg + 5'h01)) : rx_cnt_reg);
			rx_hist_reg  <= bif.tick ? {rx_hist_reg[1:0], rx_in} : rx_hist_reg; // [R14]
			ir_hold_reg  <= !rx_raw ? 1'b0 : ((bif.tick && ir_cnt_reg == samples - 5'h01) ?
				1'b1 : ir_hold_reg);                                     // [R16]
			ir_cnt_reg   <= !rx_raw ? 5'h00 : (bif.tick ? 5'(ir_cnt_reg + 5'h01) : ir_cnt_reg);
		end
	end

	// Buffer storage; an overflow set beats the clearing read
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rx_wp_reg   <= 1'b0;
			rx_rp_reg   <= 1'b0;
			rx_cnt2_reg <= 2'h0;
			ovf_reg     <= 1'b0;
		end else begin
			rx_wp_reg   <= rx_wp_reg ^ rx_wr;
			rx_rp_reg   <= rx_rp_reg ^ rx_pop;
			rx_cnt2_reg <= 2'(rx_cnt2_reg + {1'b0, rx_wr} - {1'b0, rx_pop}); // [R7]
			ovf_reg     <= rx_ovf || (ovf_reg && !rx_pop);               // [R8]
		end
		if (rx_wr) begin
			rx_mem[rx_wp_reg] <= {rx_ferr, rx_perr_reg, rx_shift_reg};
		end
	end

	assign rx_data        = rx_mem[rx_rp_reg][8:0];
	assign rx_parity_err  = rx_mem[rx_rp_reg][9];                        // [R8]
	assign rx_frame_err   = rx_mem[rx_rp_reg][10];                       // [R8]
	assign rx_valid       = rx_cnt2_reg != 2'h0;
	assign rxc_irq        = rx_valid;                                    // [R9]
	assign rx_overflow    = ovf_reg;
	assign start_of_frame = sof_reg;

	// Auto-baud: five falls of the sync field span eight bit times
	logic [16:0] ab_cnt_reg;
	logic [2:0]  ab_falls_reg;
	logic        ab_arm_reg, brk_reg, rx_in_d_reg;
	wire         rx_fell = rx_in_d_reg && !rx_in;
	wire         ab_hit  = ab_arm_reg && rx_fell && ab_falls_reg == AB_FALLS - 3'h1;
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ab_cnt_reg   <= AB_CNT_RST;
			ab_falls_reg <= 3'h0;
			ab_arm_reg   <= 1'b0;
			ab_reg       <= DIV_RST;
			ab_valid_reg <= 1'b0;
			brk_reg      <= 1'b0;
			rx_in_d_reg  <= 1'b1;
		end else begin
			rx_in_d_reg  <= rx_in;
			brk_reg      <= rx_brk;
			ab_arm_reg   <= lin_auto_baud && (rx_brk || (ab_arm_reg && !ab_hit)); // [R17]
			ab_falls_reg <= rx_brk ? 3'h0 : ((ab_arm_reg && rx_fell) ?
				3'(ab_falls_reg + 3'h1) : ab_falls_reg);
			ab_cnt_reg   <= (rx_brk || ab_falls_reg == 3'h0) ? AB_CNT_RST : 17'(ab_cnt_reg + 17'h1);
			ab_reg       <= ab_hit ? (double_speed_sampling ? ab_cnt_reg[15:0] :
				ab_cnt_reg[16:1]) : ab_reg;                              // [R17]
			ab_valid_reg <= lin_auto_baud && (ab_hit || ab_valid_reg);
		end
	end
	assign break_detect    = brk_reg;
	assign auto_baud       = ab_reg;
	assign auto_baud_valid = ab_valid_reg;
endmodule // usp_top
`default_nettype wire

// ---- test/usp_top_sva.sv ----
/*
 Checker of the serial port top-level ports.
 Assumes one clock domain and sys_rst synchronous, active high.
*/
`timescale 1ns/1ps
`default_nettype none
module usp_top_sva import usp_pkg::*; (
	input wire logic       clk,
	input wire logic       sys_rst,
	input wire logic [1:0] op_mode,
	input wire logic       infrared_pulse_codec,
	input wire logic       tx_write,
	input wire logic       tx_ready,
	input wire logic       dre_irq,
	input wire logic       rx_valid,
	input wire logic       rxc_irq,
	input wire logic       rx_overflow,
	input wire logic       txc_irq,
	input wire logic       txd,
	input wire logic       rxd_out,
	input wire logic       transfer_clock_pin_oe,
	input wire logic       rs485_driver_enable
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	// Line rests high whenever no frame is moving
	idle_high_a: assert property (!rs485_driver_enable |-> txd) else $error("txd low while idle");
	ready_drop_a: assert property (tx_write && tx_ready |=> !tx_ready) else $error("buffer not taken");
	dre_match_a: assert property (dre_irq == tx_ready) else $error("empty request wrong");
	rxc_match_a: assert property (rxc_irq == rx_valid) else $error("receive request wrong");
	shared_pin_a: assert property (rxd_out == txd) else $error("shared pin differs");
	clk_pin_a: assert property (op_mode == MODE_ASYNC |-> !transfer_clock_pin_oe) else $error("clock pin driven");
	driver_on_a: assert property ($fell(txd) |-> rs485_driver_enable) else $error("driver off in frame");
	ovf_cause_a: assert property ($rose(rx_overflow) |-> $past(rx_valid)) else $error("overflow without data");
	// Eight clocks per bit at the fastest asynchronous setting
	bit_width_a: assert property ($fell(txd) && op_mode == MODE_ASYNC && !infrared_pulse_codec
		|-> !txd [*8]) else $error("bit too short");
	done_empty_a: assert property ($rose(txc_irq) |-> txd && tx_ready) else $error("done too early");
endmodule // usp_top_sva
bind usp_top usp_top_sva chk_i (.clk, .sys_rst, .op_mode, .infrared_pulse_codec, .tx_write,
	.tx_ready, .dre_irq, .rx_valid, .rxc_irq, .rx_overflow, .txc_irq, .txd, .rxd_out,
	.transfer_clock_pin_oe, .rs485_driver_enable);
`default_nettype wire

// ---- test/usp_far_end.sv ----
/*
 Remote asynchronous serial device: sends frames and decodes frames.
 Assumes bit time in clocks is given by the caller per call.
*/
`timescale 1ns/1ps
`default_nettype none
module usp_far_end (
	input  wire logic clk,
	input  wire logic txd,
	output var logic  rxd
);
	initial rxd = 1'b1;
	// Start, data in chosen order, parity, stop; line then idles high
	task automatic send(input logic [8:0] d, input int n, input logic msb, input logic [1:0] pm,
		input logic flip, input logic stop_ok, input int bt);
		logic p;
		p = pm[0] ^ flip;
		rxd = 1'b0;
		repeat (bt) @(negedge clk);
		for (int i = 0; i < n; i++) begin
			rxd = d[msb ? n - 1 - i : i];
			p = p ^ d[i];
			repeat (bt) @(negedge clk);
		end
		if (pm[1]) begin
			rxd = p;
			repeat (bt) @(negedge clk);
		end
		rxd = stop_ok;
		repeat (bt) @(negedge clk);
		rxd = 1'b1;
		repeat (bt) @(negedge clk);
	endtask
	// Mid-bit sampling; gap counts clocks from last stop sample to next start
	task automatic grab(input int n, input int bt, input logic msb, input logic [1:0] pm,
		input logic two, output logic [8:0] d, output logic p, output int gap);
		d = '0;
		p = 1'b0;
		gap = 0;
		// A frame that follows directly has already fallen, so poll the level
		while (txd === 1'b1) @(posedge clk);
		repeat (bt / 2) @(posedge clk);
		for (int i = 0; i < n; i++) begin
			repeat (bt) @(posedge clk);
			d[msb ? n - 1 - i : i] = txd;
		end
		if (pm[1]) begin
			repeat (bt) @(posedge clk);
			p = txd;
		end
		repeat (two ? 2 : 1) begin
			repeat (bt) @(posedge clk);
			if (txd !== 1'b1) gap = 999;
		end
		while (txd === 1'b1 && gap < 3 * bt) begin
			@(posedge clk);
			gap++;
		end
	endtask
endmodule // usp_far_end
`default_nettype wire

// ---- test/tb_usp_top.sv ----
/*
 Self-checking bench of the serial port in asynchronous mode.
 Assumes the far-end model and the bound checker beside it.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_usp_top;
	import usp_pkg::*;
	logic clk, sys_rst, msb_first, two_stop, double_speed_sampling, multiproc, tx_enable, rx_enable;
	logic tx_write, rx_read, txc_clear, tx_ready, rx_valid, rx_overflow, txc_irq, txd, line;
	logic rx_frame_err, rx_parity_err;
	logic [1:0] parity_mode;
	logic [3:0] data_bits;
	logic [8:0] tx_data, rx_data;
	logic [15:0] baud_div;
	int mismatches, compares, cycles;
	usp_far_end far (.clk(clk), .txd(txd), .rxd(line));
	usp_top uut (.clk, .sys_rst, .tx_enable, .rx_enable, .op_mode(MODE_ASYNC),
		.data_bits, .msb_first, .parity_mode, .two_stop, .double_speed_sampling,
		.one_wire(1'b0), .multiproc, .infrared_pulse_codec(1'b0), .lin_auto_baud(1'b0),
		.baud_div, .tx_data, .tx_write, .tx_ready, .rx_data, .rx_frame_err,
		.rx_parity_err, .rx_valid, .rx_read, .rx_overflow, .txc_clear, .txc_irq, .dre_irq(),
		.rxc_irq(), .start_of_frame(), .break_detect(), .auto_baud(), .auto_baud_valid(),
		.rxd_in(line), .rxd_out(), .rxd_oe(), .txd, .transfer_clock_pin_in(1'b0),
		.transfer_clock_pin_out(), .transfer_clock_pin_oe(), .rs485_driver_enable());
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task chk(input logic ok, input string m);
		compares++;
		if (ok !== 1'b1) begin
			mismatches++;
			$display("CHECK FAILED t=%0t %s", $time, m);
		end
	endtask
	task give_verdict;
		if (mismatches == 0 && compares > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// Hang guard: far more than all frames need
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			give_verdict();
		end
	end
	function automatic logic [8:0] msk(input int n);
		return 9'((10'h001 << n) - 1);
	endfunction
	function automatic logic par(input logic [8:0] d, input int n, input logic odd);
		par = odd;
		for (int i = 0; i < n; i++) par = par ^ d[i];
	endfunction
	task cfg(input int n, input logic m, input logic [1:0] pm, input logic two, input logic ds);
		@(negedge clk);
		{data_bits, msb_first, parity_mode, two_stop, double_speed_sampling} = {4'(n), m, pm, two, ds};
	endtask
	task put(input logic [8:0] d);
		for (int k = 0; k < 2000 && tx_ready !== 1'b1; k++) @(negedge clk);
		{tx_data, tx_write} = {d, 1'b1};
		@(negedge clk) tx_write = 1'b0;
		chk(tx_ready === 1'b0, "buffer still free");
	endtask
	task pop;
		@(negedge clk) rx_read = 1'b1;
		@(negedge clk) rx_read = 1'b0;
	endtask
	// Two frames back to back, then completion request and its clearing
	task automatic row(input int n, input logic m, input logic [1:0] pm, input logic two,
		input logic ds, input logic [8:0] a, input logic [8:0] b);
		logic [8:0] ga, gb;
		logic pa, pb;
		int g1, g2, bt;
		bt = ds ? 8 : 16;
		cfg(n, m, pm, two, ds);
		fork
			begin put(a); put(b); end
			begin far.grab(n, bt, m, pm, two, ga, pa, g1); far.grab(n, bt, m, pm, two, gb, pb, g2); end
		join
		chk(ga === (a & msk(n)) && gb === (b & msk(n)), "tx data");
		chk(!pm[1] || (pa === par(a, n, pm[0]) && pb === par(b, n, pm[0])), "tx parity");
		chk(g1 < bt, "gap between frames");
		chk(txc_irq === 1'b1, "no tx done");
		@(negedge clk) txc_clear = 1'b1;
		@(negedge clk) txc_clear = 1'b0;
		chk(txc_irq === 1'b0, "tx done stuck");
	endtask
	// Two held entries, third lost; parity and stop faults flagged apart
	task rx_case;
		cfg(8, 1'b0, 2'b10, 1'b0, 1'b0);
		far.send(9'h03C, 8, 1'b0, 2'b10, 1'b0, 1'b1, 16);
		far.send(9'h0C3, 8, 1'b0, 2'b10, 1'b1, 1'b1, 16);
		far.send(9'h055, 8, 1'b0, 2'b10, 1'b0, 1'b1, 16);
		chk(rx_overflow === 1'b1 && rx_valid === 1'b1, "no overflow");
		chk(rx_data[7:0] === 8'h3C && rx_parity_err === 1'b0, "first entry");
		pop();
		chk(rx_data[7:0] === 8'hC3 && rx_parity_err === 1'b1, "parity flag");
		pop();
		chk(rx_valid === 1'b0 && rx_overflow === 1'b0, "not drained");
		far.send(9'h011, 8, 1'b0, 2'b10, 1'b0, 1'b0, 16);
		chk(rx_frame_err === 1'b1 && rx_parity_err === 1'b0, "frame flag");
		pop();
	endtask
	// Frames without the address bit never reach the buffer
	task mp_case;
		cfg(9, 1'b0, 2'b00, 1'b0, 1'b0);
		{multiproc, tx_enable} = 2'h2;
		far.send(9'h0AA, 9, 1'b0, 2'b00, 1'b0, 1'b1, 16);
		chk(rx_valid === 1'b0 && tx_ready === 1'b0, "unaddressed kept");
		far.send(9'h1AA, 9, 1'b0, 2'b00, 1'b0, 1'b1, 16);
		chk(rx_valid === 1'b1 && rx_data === 9'h1AA, "address lost");
		pop();
		{multiproc, tx_enable} = 2'h1;
	endtask
	initial begin
		{mismatches, compares, cycles} = '0;
		{sys_rst, tx_enable, rx_enable, tx_write, rx_read, txc_clear, multiproc, tx_data} =
			{3'h7, 13'h0000};
		{baud_div, data_bits, msb_first, parity_mode, two_stop, double_speed_sampling} =
			{16'h0040, 4'h8, 5'h00};
		repeat (5) @(posedge clk);
		@(negedge clk) sys_rst = 1'b0;
		row(5, 1'b0, 2'b00, 1'b0, 1'b0, 9'h015, 9'h00A);
		row(8, 1'b1, 2'b10, 1'b1, 1'b1, 9'h0A5, 9'h03C);
		row(9, 1'b0, 2'b11, 1'b0, 1'b0, 9'h1C6, 9'h039);
		rx_case();
		mp_case();
		give_verdict();
	end
endmodule // tb_usp_top
`default_nettype wire
